// ===== hw/fpec_top.sv
// Flash program and erase control registers and mode sequencing
`timescale 1ns/10ps
module fpec_top #(
    parameter bit HAS_FLASH   = 1'b1,
    parameter bit LARGE_ARRAY = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic        bus_sel_i,
    input  wire logic        bus_wr_i,
    input  wire logic [7:0]  bus_wdata_i,
    output logic [7:0]       bus_rdata_o,
    output logic             bus_ack_o,
    input  wire logic        array_error_i,
    input  wire logic [15:0] array_addr_i,
    output logic [2:0]       flash_mode_o,
    output logic             error_protect_o,
    output logic             erase_allowed_o,
    output logic             power_down_disable_o
);
    localparam int NUM_BLOCKS = fpec_pkg::NUM_BLOCKS;

    logic [7:0]         flash_mode_control;
    logic [7:0]         flash_error_status;
    logic [7:0]         flash_power_control;
    logic [7:0]         erase_block_select;
    logic [7:0]         flash_regs_access_enable;
    logic               busy;
    logic               take;
    logic               do_wr;
    logic               ctrl_ok;
    logic               error_flag;
    logic [7:0]         next_mode_ctrl;
    logic [7:0]         next_block_sel;
    logic [7:0]         rdata;
    logic [NUM_BLOCKS-1:0] block_hit;
    logic [15:0]        last_large;
    logic [2:0]         sel_count;
    fpec_pkg::fpec_mode_t mode;

    assign take    = bus_sel_i && !busy;
    assign do_wr   = take && bus_wr_i && HAS_FLASH;
    assign ctrl_ok = flash_regs_access_enable[fpec_pkg::BIT_REGS_ENABLE];
    assign error_flag = flash_error_status[fpec_pkg::BIT_ERROR_FLAG];

    // Two-state bus cycle: take in first state, answer in second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy      <= 1'b0;
            bus_ack_o <= 1'b0;
        end else if (ce_i) begin
            busy      <= take;
            bus_ack_o <= take;
        end
    end

    // Mode control next value
    always_comb begin
        next_mode_ctrl = bus_wdata_i & fpec_pkg::MODE_CTRL_MASK;
        if (!bus_wdata_i[fpec_pkg::BIT_WRITE_EN]) begin
            next_mode_ctrl = fpec_pkg::REG_RESET;
        end
        if (!flash_mode_control[fpec_pkg::BIT_WRITE_EN]) begin
            next_mode_ctrl = fpec_pkg::REG_RESET;
            next_mode_ctrl[fpec_pkg::BIT_WRITE_EN] = bus_wdata_i[fpec_pkg::BIT_WRITE_EN];
        end
        if (!flash_mode_control[fpec_pkg::BIT_ERASE_SETUP]) begin
            next_mode_ctrl[fpec_pkg::BIT_ERASE] = 1'b0;
        end
        if (!flash_mode_control[fpec_pkg::BIT_PROG_SETUP]) begin
            next_mode_ctrl[fpec_pkg::BIT_PROGRAM] = 1'b0;
        end
        if (error_flag) begin
            next_mode_ctrl[fpec_pkg::BIT_ERASE]   = 1'b0;
            next_mode_ctrl[fpec_pkg::BIT_PROGRAM] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_mode_control <= fpec_pkg::REG_RESET;
        end else if (ce_i) begin
            if (do_wr && ctrl_ok && bus_addr_i == fpec_pkg::ADDR_MODE_CTRL) begin
                flash_mode_control <= next_mode_ctrl;
            end else if (error_flag) begin
                flash_mode_control[fpec_pkg::BIT_ERASE]   <= 1'b0;
                flash_mode_control[fpec_pkg::BIT_PROGRAM] <= 1'b0;
            end
        end
    end

    // Count of block bits in a write
    always_comb begin
        sel_count = 3'h0;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            sel_count = sel_count + {2'h0, bus_wdata_i[i]};
        end
        next_block_sel = bus_wdata_i & fpec_pkg::BLOCK_SEL_MASK;
        if (sel_count > 3'h1) begin
            next_block_sel = fpec_pkg::REG_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            erase_block_select <= fpec_pkg::REG_RESET;
        end else if (ce_i) begin
            if (!flash_mode_control[fpec_pkg::BIT_WRITE_EN]) begin
                erase_block_select <= fpec_pkg::REG_RESET;
            end else if (do_wr && ctrl_ok && bus_addr_i == fpec_pkg::ADDR_BLOCK_SEL) begin
                erase_block_select <= next_block_sel;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_power_control <= fpec_pkg::REG_RESET;
        end else if (ce_i) begin
            if (do_wr && ctrl_ok && bus_addr_i == fpec_pkg::ADDR_POWER_CTRL) begin
                flash_power_control <= bus_wdata_i & fpec_pkg::TOP_BIT_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_regs_access_enable <= fpec_pkg::REG_RESET;
        end else if (ce_i) begin
            if (do_wr && bus_addr_i == fpec_pkg::ADDR_ACCESS_EN) begin
                flash_regs_access_enable <= bus_wdata_i & fpec_pkg::TOP_BIT_MASK;
            end
        end
    end

    // Error flag sticky while write enable stays set; writes never touch it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_error_status <= fpec_pkg::REG_RESET;
        end else if (ce_i) begin
            if (array_error_i && (flash_mode_control[fpec_pkg::BIT_ERASE] ||
                                  flash_mode_control[fpec_pkg::BIT_PROGRAM])) begin
                flash_error_status <= fpec_pkg::TOP_BIT_MASK;
            end else if (!flash_mode_control[fpec_pkg::BIT_WRITE_EN]) begin
                flash_error_status <= fpec_pkg::REG_RESET;
            end
        end
    end

    // Block address ranges
    assign last_large = LARGE_ARRAY ? fpec_pkg::BLOCK_END_LARGE : fpec_pkg::BLOCK_END_SMALL;
    fpec_block_range u_blk0 (
        .addr_i (array_addr_i),
        .base_i (fpec_pkg::BLOCK_BASE_0),
        .last_i (fpec_pkg::BLOCK_BASE_1 - 16'h0001),
        .hit_o  (block_hit[0])
    );
    fpec_block_range u_blk1 (
        .addr_i (array_addr_i),
        .base_i (fpec_pkg::BLOCK_BASE_1),
        .last_i (fpec_pkg::BLOCK_BASE_2 - 16'h0001),
        .hit_o  (block_hit[1])
    );
    fpec_block_range u_blk2 (
        .addr_i (array_addr_i),
        .base_i (fpec_pkg::BLOCK_BASE_2),
        .last_i (fpec_pkg::BLOCK_BASE_3 - 16'h0001),
        .hit_o  (block_hit[2])
    );
    fpec_block_range u_blk3 (
        .addr_i (array_addr_i),
        .base_i (fpec_pkg::BLOCK_BASE_3),
        .last_i (fpec_pkg::BLOCK_BASE_4 - 16'h0001),
        .hit_o  (block_hit[3])
    );
    fpec_block_range u_blk4 (
        .addr_i (array_addr_i),
        .base_i (fpec_pkg::BLOCK_BASE_4),
        .last_i (last_large),
        .hit_o  (block_hit[4])
    );

    // Mode decode, priority program, erase, verifies, setups
    always_comb begin
        mode = fpec_pkg::FPEC_READ;
        if (flash_mode_control[fpec_pkg::BIT_PROGRAM]) begin
            mode = fpec_pkg::FPEC_PROGRAM;
        end else if (flash_mode_control[fpec_pkg::BIT_ERASE]) begin
            mode = fpec_pkg::FPEC_ERASE;
        end else if (flash_mode_control[fpec_pkg::BIT_ERASE_VERIFY]) begin
            mode = fpec_pkg::FPEC_ERASE_VERIFY;
        end else if (flash_mode_control[fpec_pkg::BIT_PROG_VERIFY]) begin
            mode = fpec_pkg::FPEC_PROG_VERIFY;
        end else if (flash_mode_control[fpec_pkg::BIT_ERASE_SETUP]) begin
            mode = fpec_pkg::FPEC_ERASE_SETUP;
        end else if (flash_mode_control[fpec_pkg::BIT_PROG_SETUP]) begin
            mode = fpec_pkg::FPEC_PROG_SETUP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_mode_o         <= fpec_pkg::FPEC_READ;
            error_protect_o      <= 1'b0;
            erase_allowed_o      <= 1'b0;
            power_down_disable_o <= 1'b0;
        end else if (ce_i) begin
            flash_mode_o         <= mode;
            error_protect_o      <= error_flag;
            erase_allowed_o      <= |(block_hit & erase_block_select[NUM_BLOCKS-1:0]);
            power_down_disable_o <= flash_power_control[fpec_pkg::BIT_POWER_DOWN];
        end
    end

    // Read mux
    always_comb begin
        rdata = fpec_pkg::REG_RESET;
        if (bus_addr_i == fpec_pkg::ADDR_ACCESS_EN) begin
            rdata = flash_regs_access_enable;
        end else if (ctrl_ok) begin
            case (bus_addr_i)
                fpec_pkg::ADDR_MODE_CTRL:  rdata = flash_mode_control;
                fpec_pkg::ADDR_ERR_STATUS: rdata = flash_error_status;
                fpec_pkg::ADDR_POWER_CTRL: rdata = flash_power_control;
                fpec_pkg::ADDR_BLOCK_SEL:  rdata = erase_block_select;
                default:                   rdata = fpec_pkg::REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_rdata_o <= fpec_pkg::REG_RESET;
        end else if (ce_i) begin
            if (take && !bus_wr_i) begin
                bus_rdata_o <= HAS_FLASH ? rdata : fpec_pkg::REG_RESET;
            end
        end
    end
endmodule

// ===== hw/fpec_pkg.sv
// Package with register map, field positions and reset values of the flash control block
package fpec_pkg;
    localparam logic [15:0] ADDR_MODE_CTRL   = 16'hf020;
    localparam logic [15:0] ADDR_ERR_STATUS  = 16'hf021;
    localparam logic [15:0] ADDR_POWER_CTRL  = 16'hf022;
    localparam logic [15:0] ADDR_BLOCK_SEL   = 16'hf023;
    localparam logic [15:0] ADDR_ACCESS_EN   = 16'hf02b;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam int          BIT_WRITE_EN     = 6;
    localparam int          BIT_ERASE_SETUP  = 5;
    localparam int          BIT_PROG_SETUP   = 4;
    localparam int          BIT_ERASE_VERIFY = 3;
    localparam int          BIT_PROG_VERIFY  = 2;
    localparam int          BIT_ERASE        = 1;
    localparam int          BIT_PROGRAM      = 0;
    localparam int          BIT_ERROR_FLAG   = 7;
    localparam int          BIT_POWER_DOWN   = 7;
    localparam int          BIT_REGS_ENABLE  = 7;
    localparam logic [7:0]  MODE_CTRL_MASK   = 8'h7f;
    localparam logic [7:0]  BLOCK_SEL_MASK   = 8'h1f;
    localparam logic [7:0]  TOP_BIT_MASK     = 8'h80;
    localparam int          NUM_BLOCKS       = 5;
    localparam logic [15:0] BLOCK_BASE_0     = 16'h0000;
    localparam logic [15:0] BLOCK_BASE_1     = 16'h0400;
    localparam logic [15:0] BLOCK_BASE_2     = 16'h0800;
    localparam logic [15:0] BLOCK_BASE_3     = 16'h0c00;
    localparam logic [15:0] BLOCK_BASE_4     = 16'h1000;
    localparam logic [15:0] BLOCK_END_SMALL  = 16'h3fff;
    localparam logic [15:0] BLOCK_END_LARGE  = 16'h7fff;
    typedef enum logic [2:0] {
        FPEC_READ,
        FPEC_PROG_SETUP,
        FPEC_PROGRAM,
        FPEC_PROG_VERIFY,
        FPEC_ERASE_SETUP,
        FPEC_ERASE,
        FPEC_ERASE_VERIFY
    } fpec_mode_t;
endpackage

// ===== hw/fpec_block_range.sv
// Address range check for one erase block
`timescale 1ns/10ps
module fpec_block_range (
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] base_i,
    input  wire logic [15:0] last_i,
    output logic             hit_o
);
    assign hit_o = (addr_i >= base_i) && (addr_i <= last_i);
endmodule

// ===== bench/fpec_cpu_model.sv
// Processor bus master model for the flash control registers
`timescale 1ns/10ps
module fpec_cpu_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  rdata_i,
    input  wire logic        ack_i,
    output logic             sel_o,
    output logic             wr_o,
    output logic [15:0]      addr_o,
    output logic [7:0]       wdata_o
);
    initial begin
        sel_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 8'h00;
    end
    // One byte access of two states, request held until ack or for at most four cycles after the first
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        int n;
        @(negedge clk_i);
        sel_o = 1'b1;
        wr_o = w;
        addr_o = a;
        wdata_o = d;
        ok = 1'b0;
        n = 0;
        @(posedge clk_i);
        while (!ok && n < 4) begin
            @(posedge clk_i);
            ok = (ack_i === 1'b1);
            n++;
        end
        q = rdata_i;
        @(negedge clk_i);
        sel_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule

// ===== bench/fpec_top_monitor.sv
// Port checker for the flash control block
`timescale 1ns/10ps
module fpec_top_monitor #(
    parameter bit HAS_FLASH   = 1'b1,
    parameter bit LARGE_ARRAY = 1'b1
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic        bus_sel_i,
    input wire logic        bus_wr_i,
    input wire logic [7:0]  bus_wdata_i,
    input wire logic [7:0]  bus_rdata_o,
    input wire logic        bus_ack_o,
    input wire logic        array_error_i,
    input wire logic [15:0] array_addr_i,
    input wire logic [2:0]  flash_mode_o,
    input wire logic        error_protect_o,
    input wire logic        erase_allowed_o,
    input wire logic        power_down_disable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_single: assert property (bus_ack_o |=> !bus_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (bus_ack_o |-> $past(bus_sel_i) && $past(ce_i))
        else $error("ack without request");
    chk_prog_entry: assert property ($rose(flash_mode_o == fpec_pkg::FPEC_PROGRAM)
        |-> $past(bus_wr_i, 2) && ($past(bus_wdata_i, 2) & 8'h01) != 8'h00)
        else $error("program mode without write");
    chk_erase_entry: assert property ($rose(flash_mode_o == fpec_pkg::FPEC_ERASE)
        |-> $past(bus_wr_i, 2) && ($past(bus_wdata_i, 2) & 8'h02) != 8'h00)
        else $error("erase mode without write");
    chk_ev_entry: assert property ($rose(flash_mode_o == fpec_pkg::FPEC_ERASE_VERIFY)
        && !error_protect_o |-> ($past(bus_wdata_i, 2) & 8'h08) != 8'h00)
        else $error("erase verify without bit");
    chk_pv_entry: assert property ($rose(flash_mode_o == fpec_pkg::FPEC_PROG_VERIFY)
        && !error_protect_o |-> ($past(bus_wdata_i, 2) & 8'h04) != 8'h00)
        else $error("program verify without bit");
    chk_err_cause: assert property ($rose(error_protect_o) |-> $past(array_error_i, 2))
        else $error("protection without error");
    chk_range_limit: assert property (erase_allowed_o |-> $past(array_addr_i) <=
        (LARGE_ARRAY ? fpec_pkg::BLOCK_END_LARGE : fpec_pkg::BLOCK_END_SMALL))
        else $error("erase allowed beyond array");
    chk_reset_clear: assert property (disable iff (1'b0) rst_i && ce_i |=>
        flash_mode_o == 3'h0 && !bus_ack_o && !error_protect_o && !erase_allowed_o)
        else $error("outputs not cleared by reset");
    cover property (flash_mode_o == fpec_pkg::FPEC_PROGRAM);
    cover property (flash_mode_o == fpec_pkg::FPEC_ERASE && erase_allowed_o);
    cover property ($rose(error_protect_o));
endmodule

bind fpec_top fpec_top_monitor #(.HAS_FLASH(HAS_FLASH), .LARGE_ARRAY(LARGE_ARRAY)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
    .bus_sel_i(bus_sel_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .array_error_i(array_error_i),
    .array_addr_i(array_addr_i), .flash_mode_o(flash_mode_o),
    .error_protect_o(error_protect_o), .erase_allowed_o(erase_allowed_o),
    .power_down_disable_o(power_down_disable_o));

// ===== bench/fpec_top_tb_top.sv
// Self-checking bench for the flash control block
`timescale 1ns/10ps
module fpec_top_tb_top;
    logic        clk_i, rst_i, ce_i, bus_sel_i, bus_wr_i, bus_ack_o, array_error_i;
    logic        error_protect_o, erase_allowed_o, power_down_disable_o;
    logic [15:0] bus_addr_i, array_addr_i;
    logic [7:0]  bus_wdata_i, bus_rdata_o;
    logic [2:0]  flash_mode_o;
    int          miscompares = 0;
    int          total_checks = 0;
    logic [7:0]  rd_q;
    logic        rd_ok;
    typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] r;} fpec_row_t;
    fpec_row_t rows [13] = '{
        '{fpec_pkg::ADDR_MODE_CTRL, 8'h40, 8'h00}, '{fpec_pkg::ADDR_ACCESS_EN, 8'hff, 8'h80},
        '{fpec_pkg::ADDR_MODE_CTRL, 8'h20, 8'h00}, '{fpec_pkg::ADDR_BLOCK_SEL, 8'h01, 8'h00},
        '{fpec_pkg::ADDR_MODE_CTRL, 8'h40, 8'h40}, '{fpec_pkg::ADDR_MODE_CTRL, 8'hc0, 8'h40},
        '{fpec_pkg::ADDR_BLOCK_SEL, 8'h03, 8'h00}, '{fpec_pkg::ADDR_BLOCK_SEL, 8'he2, 8'h02},
        '{fpec_pkg::ADDR_MODE_CTRL, 8'h42, 8'h40}, '{fpec_pkg::ADDR_MODE_CTRL, 8'h41, 8'h40},
        '{fpec_pkg::ADDR_ERR_STATUS, 8'hff, 8'h00}, '{fpec_pkg::ADDR_POWER_CTRL, 8'hff, 8'h80},
        '{16'hf030, 8'hff, 8'h00}};

    fpec_top fpec_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_addr_i(bus_addr_i),
        .bus_sel_i(bus_sel_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
        .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .array_error_i(array_error_i),
        .array_addr_i(array_addr_i), .flash_mode_o(flash_mode_o),
        .error_protect_o(error_protect_o), .erase_allowed_o(erase_allowed_o),
        .power_down_disable_o(power_down_disable_o));
    fpec_cpu_model fpec_cpu_model_i (.clk_i(clk_i), .rdata_i(bus_rdata_o), .ack_i(bus_ack_o),
        .sel_o(bus_sel_i), .wr_o(bus_wr_i), .addr_o(bus_addr_i), .wdata_o(bus_wdata_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Write a byte, read it back, then look at the mode output
    task automatic step(input logic [15:0] a, input logic [7:0] d, input logic [7:0] r,
                        input logic [2:0] m);
        logic [7:0] q;
        logic       ok;
        fpec_cpu_model_i.access(1'b1, a, d, q, ok);
        check("write ack", {7'h00, ok}, 8'h01);
        fpec_cpu_model_i.access(1'b0, a, 8'h00, q, ok);
        check("read back", q, r);
        check("mode", {5'h00, flash_mode_o}, {5'h00, m});
    endtask

    task automatic addr_chk(input logic [15:0] a, input logic exp);
        @(negedge clk_i);
        array_addr_i = a;
        @(negedge clk_i);
        check("erase allowed", {7'h00, erase_allowed_o}, {7'h00, exp});
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end

    initial begin
        ce_i = 1'b1;
        rst_i = 1'b1;
        array_error_i = 1'b0;
        array_addr_i = 16'h0000;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        check("reset mode", {5'h00, flash_mode_o}, 8'h00);
        foreach (rows[i]) step(rows[i].a, rows[i].d, rows[i].r, fpec_pkg::FPEC_READ);
        check("power down", {7'h00, power_down_disable_o}, 8'h01);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h60, 8'h60, fpec_pkg::FPEC_ERASE_SETUP);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h62, 8'h62, fpec_pkg::FPEC_ERASE);
        addr_chk(16'h0400, 1'b1);
        addr_chk(16'h0800, 1'b0);
        @(negedge clk_i) array_error_i = 1'b1;
        @(negedge clk_i) array_error_i = 1'b0;
        @(negedge clk_i);
        check("protect", {7'h00, error_protect_o}, 8'h01);
        step(fpec_pkg::ADDR_ERR_STATUS, 8'h00, 8'h80, fpec_pkg::FPEC_ERASE_SETUP);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h40, 8'h40, fpec_pkg::FPEC_READ);
        step(fpec_pkg::ADDR_BLOCK_SEL, 8'h01, 8'h01, fpec_pkg::FPEC_READ);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h00, 8'h00, fpec_pkg::FPEC_READ);
        addr_chk(16'h0000, 1'b0);
        step(fpec_pkg::ADDR_ERR_STATUS, 8'h00, 8'h00, fpec_pkg::FPEC_READ);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h40, 8'h40, fpec_pkg::FPEC_READ);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h50, 8'h50, fpec_pkg::FPEC_PROG_SETUP);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h51, 8'h51, fpec_pkg::FPEC_PROGRAM);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h54, 8'h54, fpec_pkg::FPEC_PROG_VERIFY);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h40, 8'h40, fpec_pkg::FPEC_READ);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h48, 8'h48, fpec_pkg::FPEC_ERASE_VERIFY);
        step(fpec_pkg::ADDR_MODE_CTRL, 8'h40, 8'h40, fpec_pkg::FPEC_READ);
        step(fpec_pkg::ADDR_BLOCK_SEL, 8'h10, 8'h10, fpec_pkg::FPEC_READ);
        addr_chk(16'h7fff, 1'b1);
        addr_chk(16'h0fff, 1'b0);
        addr_chk(16'h8000, 1'b0);
        // Clock enable low: request never taken, registers frozen
        @(negedge clk_i) ce_i = 1'b0;
        fpec_cpu_model_i.access(1'b1, fpec_pkg::ADDR_BLOCK_SEL, 8'h01, rd_q, rd_ok);
        check("frozen ack", {7'h00, rd_ok}, 8'h00);
        @(negedge clk_i) ce_i = 1'b1;
        fpec_cpu_model_i.access(1'b0, fpec_pkg::ADDR_BLOCK_SEL, 8'h00, rd_q, rd_ok);
        check("frozen block", rd_q, 8'h10);
        // Reset in mid-run clears every register
        @(negedge clk_i) rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        check("reset power", {7'h00, power_down_disable_o}, 8'h00);
        fpec_cpu_model_i.access(1'b0, fpec_pkg::ADDR_ACCESS_EN, 8'h00, rd_q, rd_ok);
        check("reset access", rd_q, 8'h00);
        complete_run();
    end
endmodule
